/* File: core/io_point_defines.svh */
`ifndef IO_POINT_DEFINES_SVH
`define IO_POINT_DEFINES_SVH

// Register byte offsets of the APB slave.
`define CTRL_OFF 12'h000
`define KEY_ENTRY_OFF 12'h004
`define KEY_CFG_OFF 12'h008
`define OUT_REG_OFF 12'h00C
`define STATUS_OFF 12'h010
`define DEMO_TIME_OFF 12'h014
`define FLOAT_FAIL_OFF 12'h018
`define FLASH_HALF_OFF 12'h01C
`define POINT_CFG_OFF 12'h020
`define ANALOG_CFG_OFF 12'h024

// Indexed regions: paddr[11:8] for points and blocks, paddr[11:6] for word arrays.
`define PT_REGION 4'h1
`define TB_REGION 4'h2
`define AI_REGION 6'h0C
`define AO_REGION 6'h0D
`define RATE_REGION 6'h0E

// Word select inside one point or block group, paddr[3:2].
`define PT_FILTER 2'h0
`define PT_ON 2'h1
`define PT_HOLD 2'h2
`define PT_RECYCLE 2'h3
`define TB_ON 2'h0
`define TB_OFF 2'h1
`define TB_SEL 2'h2

// Field positions.
`define CTRL_DEMO 0
`define CTRL_SH3 1
`define CTRL_SH4 2
`define CTRL_SCHEME 4
`define CTRL_UNLOCK 8
`define PC_INVERT 0
`define PC_SLOW 4
`define PC_FLASH 8
`define PC_MIRROR 12
`define PC_TB_EN 16
`define PC_TB_SRC 20
`define AC_AI_MODE 0
`define AC_AO_MODE 4
`define AC_AVG 8
`define ST_COND 0
`define ST_PHYS 8
`define ST_TB 16
`define ST_FAIL 24

// Reset values.
`define KEY_RST 16'h0000
`define FLASH_HALF_RST 16'h0032
`define DEMO_TIME_RST 16'h000A
`define DEMO_PAT_RST 4'h1

// Timing.
`define MS_NS 1000000
`define CLK_NS 10
`define TICKS_PER_STEP 4'hA

// Analog scaling.
`define FULL_SCALE 16'h4E20
`define LIVE_ZERO 16'h0FA0
`define AVG_MAX 3'h5

`endif

/* File: core/io_point_pkg.sv */
package io_point_pkg;

  typedef enum logic [3:0] {
    SCH_OFF,
    SCH_SP_FLIPFLOP,
    SCH_SP_STARTS,
    SCH_SP_RUNTIME,
    SCH_UP_NOALT,
    SCH_UP_FLIPFLOP,
    SCH_UP_STARTS,
    SCH_UP_RUNTIME,
    SCH_DN_NOALT,
    SCH_DN_FLIPFLOP,
    SCH_DN_STARTS,
    SCH_DN_RUNTIME
  } scheme_e;

  typedef logic [15:0] word16_t;

endpackage

/* File: core/point_drive_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface point_drive_if;
  logic cmd;
  logic force_off;
  logic flash_en;
  logic t10;
  logic t1s;
  logic phys;
  logic [15:0] on_t;
  logic [15:0] hold_t;
  logic [15:0] rcy;
  logic [15:0] flash_half;
  modport ctl(output cmd, output force_off, output flash_en, output t10, output t1s, output on_t, output hold_t,
              output rcy, output flash_half, input phys);
  modport point(input cmd, input force_off, input flash_en, input t10, input t1s, input on_t, input hold_t,
                input rcy, input flash_half, output phys);
endinterface // point_drive_if

`default_nettype wire

/* File: core/point_drive.sv */
`timescale 1ns/1ps
`default_nettype none

module point_drive (
  input wire logic pclk,
  input wire logic presetn,
  point_drive_if.point bus
);

  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] rc;
    logic ph;
    logic cmd_prev;
    logic phys;
  } drv_s;

  drv_s q;
  drv_s n;
  logic fall;
  logic rise;

  always_comb begin
    n = q;
    fall = q.cmd_prev & ~bus.cmd;
    rise = bus.cmd & ~q.cmd_prev;
    n.cmd_prev = bus.cmd;
    if (fall && bus.rcy != 16'h0000) begin
      n.rc = bus.rcy; // RULE9
    end else if (q.rc != 16'h0000 && bus.t1s) begin
      n.rc = q.rc - 16'h0001; // RULE9
    end
    if (!bus.cmd) begin
      n.ph = 1'b0;
      n.cnt = 16'h0000;
    end else if (rise) begin
      if (bus.flash_en) begin
        n.ph = 1'b1; // RULE22
        n.cnt = bus.flash_half;
      end else if (bus.on_t != 16'h0000) begin
        n.ph = 1'b1; // RULE4
        n.cnt = bus.on_t;
      end else if (bus.hold_t != 16'h0000) begin
        n.ph = 1'b0; // RULE6
        n.cnt = bus.hold_t;
      end else begin
        n.ph = 1'b1;
      end
    end else if (bus.t10 && q.cnt != 16'h0000) begin
      if (q.cnt != 16'h0001) begin
        n.cnt = q.cnt - 16'h0001;
      end else if (bus.flash_en) begin
        n.ph = ~q.ph; // RULE7
        n.cnt = bus.flash_half;
      end else if (bus.on_t != 16'h0000 && bus.hold_t != 16'h0000) begin
        n.ph = ~q.ph; // RULE5
        n.cnt = q.ph ? bus.hold_t : bus.on_t;
      end else if (bus.on_t != 16'h0000) begin
        n.ph = 1'b0; // RULE4
        n.cnt = 16'h0000;
      end else begin
        n.ph = 1'b1; // RULE6
        n.cnt = 16'h0000;
      end
    end
    // The recycle wait also masks a new command, so a pulse may be swallowed while it runs.
    n.phys = n.ph & bus.cmd & ~bus.force_off & (n.rc == 16'h0000); // RULE9
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign bus.phys = q.phys;

endmodule // point_drive

`default_nettype wire

/* File: core/io_point_conditioning_and_setpoint.sv */
// Functional notes
// RULE1: Invert input point when inversion is set.
// RULE2: Accept input after stable filter time.
// RULE3: Slow mode measures interval; fast counts pulses.
// RULE4: On-time alone gives a one-shot pulse.
// RULE5: On and hold-off together cycle PWM.
// RULE6: Hold-off alone delays output turn-on.
// RULE7: Flash toggles output while register true.
// RULE8: Software should not mix timers with flash.
// RULE9: Recycle holdoff blocks output after falling register.
// RULE10: Mode 0 is 0-20000, 1 is 0-16000.
// RULE11: Boxcar average of two-power samples, 0 off.
// RULE12: Twelve-way control scheme selector.
// RULE13: Third block shuts first two outputs, setpoint only.
// RULE14: Fourth block shuts first two outputs always.
// RULE15: No float change in time stops demands.
// RULE16: Mirror copies conditioned input into output register.
// RULE17: Threshold source is scaled analog input or output.
// RULE18: On below off: on low, off high.
// RULE19: On above off: on high, off low.
// RULE20: Configuration writes need the write key first.
// RULE21: Demo mode cycles inputs every cycle time.
// RULE22: Flash half-period configurable, starts with output on.
// RULE23: All timers from one prescaled tick, reset clears.
// RULE24: Between levels the threshold output holds.
`include "io_point_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module io_point_conditioning_and_setpoint #(
  parameter int NPTS = 4,
  parameter int MS_CYCLES = `MS_NS / `CLK_NS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic [NPTS-1:0] input_point,
  input wire logic [NPTS-1:0][15:0] sensed_level,
  input wire logic sensed_valid,
  output logic [NPTS-1:0] output_relay,
  output logic [NPTS-1:0][15:0] driven_level,
  output logic [NPTS-1:0] point_state
);

  // Point fields share 4-bit slots and indices come straight from address bits, so NPTS is 2 or 4.
  localparam int IW = $clog2(NPTS);
  localparam int PW = $clog2(MS_CYCLES);

  typedef struct packed {
    logic [PW-1:0] pre;
    logic [3:0] c10;
    logic [3:0] c100;
    logic [3:0] c1s;
    logic t1ms;
    logic t10;
    logic t100;
    logic t1s;
    logic demo_en;
    logic sh3;
    logic sh4;
    io_point_pkg::scheme_e scheme;
    logic [15:0] key_cfg;
    logic unlocked;
    logic [NPTS-1:0] out_reg;
    logic [15:0] demo_time;
    logic [15:0] ff_time;
    logic [15:0] flash_half;
    logic [NPTS-1:0] invert;
    logic [NPTS-1:0] slow;
    logic [NPTS-1:0] flash;
    logic [NPTS-1:0] mirror;
    logic [NPTS-1:0] tb_en;
    logic [NPTS-1:0] tb_src;
    logic [NPTS-1:0] ai_mode;
    logic [NPTS-1:0] ao_mode;
    logic [2:0] avg_code;
    logic [NPTS-1:0][15:0] filt;
    logic [NPTS-1:0][15:0] on_t;
    logic [NPTS-1:0][15:0] hold_t;
    logic [NPTS-1:0][15:0] rcy;
    logic [NPTS-1:0][15:0] tb_on;
    logic [NPTS-1:0][15:0] tb_off;
    logic [NPTS-1:0][IW-1:0] tb_idx;
    logic [NPTS-1:0][15:0] ao_val;
    logic [NPTS-1:0][15:0] drv;
    logic [NPTS-1:0][21:0] ai_acc;
    logic [5:0] ai_cnt;
    logic [NPTS-1:0][15:0] ai_scaled;
    logic [NPTS-1:0] cond;
    logic [NPTS-1:0][15:0] fcnt;
    logic [NPTS-1:0][15:0] rate;
    logic [NPTS-1:0][15:0] rcnt;
    logic [NPTS-1:0] tb_out;
    logic [15:0] demo_cnt;
    logic [NPTS-1:0] demo_pat;
    logic lead;
    logic d1_prev;
    logic [15:0] ff_cnt;
    logic ff_fail;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } st_s;

  st_s q;
  st_s n;
  logic [NPTS-1:0] phys_w;
  logic [NPTS-1:0] cmd;
  logic [NPTS-1:0] force_off;
  logic [NPTS-1:0] raw;
  logic [NPTS-1:0] edge_up;
  logic [31:0] rd;
  logic hit;
  logic wr;
  logic setup;
  logic [IW-1:0] pi;
  logic [1:0] fld;
  logic [15:0] src;
  logic [15:0] avg;
  logic d1;
  logic d2;
  logic setpoint_fam;
  logic shut;
  logic float_chg;
  int k;

  ////////////////////////////////////////////////////////////////////////////////
  // Scaling helpers shared by the analog paths, and the saturating step used by the rate counters.

  function automatic logic [15:0] clamp_full(input logic [16:0] v);
    clamp_full = (v > {1'b0, `FULL_SCALE}) ? `FULL_SCALE : v[15:0];
  endfunction

  function automatic logic [15:0] scale_in(input logic [15:0] raw_v, input logic mode);
    if (mode) begin
      scale_in = (raw_v < `LIVE_ZERO) ? 16'h0000 : clamp_full({1'b0, raw_v}) - `LIVE_ZERO; // RULE10
    end else begin
      scale_in = clamp_full({1'b0, raw_v}); // RULE10
    end
  endfunction

  function automatic logic [15:0] scale_out(input logic [15:0] v, input logic mode);
    scale_out = mode ? clamp_full({1'b0, v} + {1'b0, `LIVE_ZERO}) : clamp_full({1'b0, v}); // RULE10
  endfunction

  function automatic logic [15:0] step(input logic [15:0] v);
    step = (v == 16'hFFFF) ? v : v + 16'h0001;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  always_comb begin
    n = q;
    rd = 32'h0000_0000;
    hit = 1'b0;
    src = 16'h0000;
    avg = 16'h0000;
    raw = '0;
    edge_up = '0;
    setup = psel & penable & ~q.pready;
    wr = psel & penable & q.pready & pwrite;
    pi = paddr[4 +: IW];
    fld = paddr[3:2];

    // One tick chain from the clock keeps every timer in step.
    n.t1ms = 1'b0;
    n.t10 = 1'b0;
    n.t100 = 1'b0;
    n.t1s = 1'b0;
    if (q.pre == PW'(MS_CYCLES - 1)) begin
      n.pre = '0; // RULE23
      n.t1ms = 1'b1;
      n.c10 = (q.c10 == `TICKS_PER_STEP - 4'h1) ? 4'h0 : q.c10 + 4'h1;
      if (q.c10 == `TICKS_PER_STEP - 4'h1) begin
        n.t10 = 1'b1;
        n.c100 = (q.c100 == `TICKS_PER_STEP - 4'h1) ? 4'h0 : q.c100 + 4'h1;
        if (q.c100 == `TICKS_PER_STEP - 4'h1) begin
          n.t100 = 1'b1;
          n.c1s = (q.c1s == `TICKS_PER_STEP - 4'h1) ? 4'h0 : q.c1s + 4'h1;
          n.t1s = (q.c1s == `TICKS_PER_STEP - 4'h1);
        end
      end
    end else begin
      n.pre = q.pre + PW'(1);
    end

    if (q.demo_en && q.demo_time != 16'h0000 && q.t100) begin
      if (q.demo_cnt + 16'h0001 >= q.demo_time) begin
        n.demo_cnt = 16'h0000;
        n.demo_pat = {q.demo_pat[NPTS-2:0], q.demo_pat[NPTS-1]}; // RULE21
      end else begin
        n.demo_cnt = q.demo_cnt + 16'h0001;
      end
    end

    for (k = 0; k < NPTS; k++) begin
      raw[k] = (q.demo_en ? q.demo_pat[k] : input_point[k]) ^ q.invert[k]; // RULE1
      if (q.filt[k] == 16'h0000) begin
        n.cond[k] = raw[k]; // RULE2
        n.fcnt[k] = 16'h0000;
      end else if (raw[k] == q.cond[k]) begin
        n.fcnt[k] = 16'h0000;
      end else if (q.t1ms) begin
        if (q.fcnt[k] + 16'h0001 >= q.filt[k]) begin
          n.cond[k] = raw[k]; // RULE2
          n.fcnt[k] = 16'h0000;
        end else begin
          n.fcnt[k] = q.fcnt[k] + 16'h0001;
        end
      end
      edge_up[k] = n.cond[k] & ~q.cond[k];
      if (q.slow[k]) begin
        if (edge_up[k]) begin
          n.rate[k] = q.rcnt[k]; // RULE3
          n.rcnt[k] = 16'h0000;
        end else if (q.t1ms) begin
          n.rcnt[k] = step(q.rcnt[k]);
        end
      end else if (q.t1s) begin
        n.rate[k] = q.rcnt[k]; // RULE3
        n.rcnt[k] = edge_up[k] ? 16'h0001 : 16'h0000;
      end else if (edge_up[k]) begin
        n.rcnt[k] = step(q.rcnt[k]);
      end

      src = q.tb_src[k] ? q.ao_val[q.tb_idx[k]] : q.ai_scaled[q.tb_idx[k]]; // RULE17
      if (!q.tb_en[k]) begin
        n.tb_out[k] = 1'b0;
      end else if (q.tb_on[k] < q.tb_off[k]) begin // RULE24
        if (src < q.tb_on[k]) begin
          n.tb_out[k] = 1'b1; // RULE18
        end else if (src > q.tb_off[k]) begin
          n.tb_out[k] = 1'b0; // RULE18
        end
      end else if (q.tb_on[k] > q.tb_off[k]) begin
        if (src > q.tb_on[k]) begin
          n.tb_out[k] = 1'b1; // RULE19
        end else if (src < q.tb_off[k]) begin
          n.tb_out[k] = 1'b0; // RULE19
        end
      end
      n.drv[k] = scale_out(q.ao_val[k], q.ao_mode[k]); // RULE10
    end

    if (sensed_valid) begin
      for (k = 0; k < NPTS; k++) begin
        n.ai_acc[k] = q.ai_acc[k] + {6'h00, sensed_level[k]}; // RULE11
      end
      if (q.ai_cnt >= 6'((7'h01 << q.avg_code) - 7'h01)) begin
        for (k = 0; k < NPTS; k++) begin
          avg = 16'(n.ai_acc[k] >> q.avg_code); // RULE11
          n.ai_scaled[k] = scale_in(avg, q.ai_mode[k]);
          n.ai_acc[k] = 22'h000000;
        end
        n.ai_cnt = 6'h00;
      end else begin
        n.ai_cnt = q.ai_cnt + 6'h01;
      end
    end

    // Control scheme: demands come from threshold blocks or float switches.
    setpoint_fam = (q.scheme == io_point_pkg::SCH_SP_FLIPFLOP) || (q.scheme == io_point_pkg::SCH_SP_STARTS) ||
                   (q.scheme == io_point_pkg::SCH_SP_RUNTIME);
    case (q.scheme) // RULE12
      io_point_pkg::SCH_OFF: begin
        d1 = 1'b0;
        d2 = 1'b0;
      end
      io_point_pkg::SCH_SP_FLIPFLOP, io_point_pkg::SCH_SP_STARTS, io_point_pkg::SCH_SP_RUNTIME: begin
        d1 = q.tb_out[0];
        d2 = q.tb_out[1];
      end
      io_point_pkg::SCH_UP_NOALT, io_point_pkg::SCH_UP_FLIPFLOP, io_point_pkg::SCH_UP_STARTS,
      io_point_pkg::SCH_UP_RUNTIME: begin
        d1 = q.cond[0];
        d2 = q.cond[1];
      end
      default: begin
        d1 = ~q.cond[0];
        d2 = ~q.cond[1];
      end
    endcase
    n.d1_prev = d1;
    if (q.scheme == io_point_pkg::SCH_UP_NOALT || q.scheme == io_point_pkg::SCH_DN_NOALT ||
        q.scheme == io_point_pkg::SCH_OFF) begin
      n.lead = 1'b0;
    end else if (d1 && !q.d1_prev) begin
      n.lead = ~q.lead; // RULE12
    end

    float_chg = (q.cond != n.cond);
    if (float_chg) begin
      n.ff_fail = 1'b0; // RULE15
      n.ff_cnt = 16'h0000;
    end else if ((d1 || d2) && !q.ff_fail && q.ff_time != 16'h0000 && q.t1s) begin
      if (q.ff_cnt + 16'h0001 >= q.ff_time) begin
        n.ff_fail = 1'b1; // RULE15
      end else begin
        n.ff_cnt = q.ff_cnt + 16'h0001;
      end
    end else if (!(d1 || d2)) begin
      n.ff_cnt = 16'h0000;
    end
    if (q.ff_fail) begin
      d1 = 1'b0; // RULE15
      d2 = 1'b0;
    end
    shut = (q.sh3 && setpoint_fam && (q.tb_out[2] || q.cond[2])) || // RULE13
           (q.sh4 && (q.tb_out[3] || q.cond[3])); // RULE14

    for (k = 0; k < NPTS; k++) begin
      cmd[k] = q.out_reg[k];
      force_off[k] = 1'b0;
    end
    if (q.scheme != io_point_pkg::SCH_OFF) begin
      cmd[0] = q.lead ? d2 : d1;
      cmd[1] = q.lead ? d1 : d2;
    end
    force_off[0] = shut; // RULE13
    force_off[1] = shut; // RULE14

    ////////////////////////////////////////////////////////////////////////////////
    // APB slave: one wait state, then pready with data from a register.
    if (paddr == `CTRL_OFF) begin
      hit = 1'b1;
      rd = {23'h000000, q.unlocked, q.scheme, 1'b0, q.sh4, q.sh3, q.demo_en};
    end else if (paddr == `KEY_ENTRY_OFF || paddr == `KEY_CFG_OFF) begin
      hit = 1'b1;
    end else if (paddr == `OUT_REG_OFF) begin
      hit = 1'b1;
      rd[NPTS-1:0] = q.out_reg;
    end else if (paddr == `STATUS_OFF) begin
      hit = 1'b1;
      rd[`ST_COND +: NPTS] = q.cond;
      rd[`ST_PHYS +: NPTS] = phys_w;
      rd[`ST_TB +: NPTS] = q.tb_out;
      rd[`ST_FAIL] = q.ff_fail;
    end else if (paddr == `DEMO_TIME_OFF) begin
      hit = 1'b1;
      rd[15:0] = q.demo_time;
    end else if (paddr == `FLOAT_FAIL_OFF) begin
      hit = 1'b1;
      rd[15:0] = q.ff_time;
    end else if (paddr == `FLASH_HALF_OFF) begin
      hit = 1'b1;
      rd[15:0] = q.flash_half;
    end else if (paddr == `POINT_CFG_OFF) begin
      hit = 1'b1;
      rd[`PC_INVERT +: NPTS] = q.invert;
      rd[`PC_SLOW +: NPTS] = q.slow;
      rd[`PC_FLASH +: NPTS] = q.flash;
      rd[`PC_MIRROR +: NPTS] = q.mirror;
      rd[`PC_TB_EN +: NPTS] = q.tb_en;
      rd[`PC_TB_SRC +: NPTS] = q.tb_src;
    end else if (paddr == `ANALOG_CFG_OFF) begin
      hit = 1'b1;
      rd[`AC_AI_MODE +: NPTS] = q.ai_mode;
      rd[`AC_AO_MODE +: NPTS] = q.ao_mode;
      rd[`AC_AVG +: 3] = q.avg_code;
    end else if (paddr[11:8] == `PT_REGION && paddr[7:4] < 4'(NPTS)) begin
      hit = 1'b1;
      rd[15:0] = (fld == `PT_FILTER) ? q.filt[pi] : (fld == `PT_ON) ? q.on_t[pi] :
                 (fld == `PT_HOLD) ? q.hold_t[pi] : q.rcy[pi];
    end else if (paddr[11:8] == `TB_REGION && paddr[7:4] < 4'(NPTS) && fld != 2'h3) begin
      hit = 1'b1;
      rd[15:0] = (fld == `TB_ON) ? q.tb_on[pi] : (fld == `TB_OFF) ? q.tb_off[pi] : 16'(q.tb_idx[pi]);
    end else if (paddr[11:6] == `AI_REGION && paddr[5:2] < 4'(NPTS)) begin
      hit = 1'b1;
      rd[15:0] = q.ai_scaled[paddr[2 +: IW]];
    end else if (paddr[11:6] == `AO_REGION && paddr[5:2] < 4'(NPTS)) begin
      hit = 1'b1;
      rd[15:0] = q.ao_val[paddr[2 +: IW]];
    end else if (paddr[11:6] == `RATE_REGION && paddr[5:2] < 4'(NPTS)) begin
      hit = 1'b1;
      rd[15:0] = q.rate[paddr[2 +: IW]];
    end

    n.pready = setup;
    if (setup) begin
      n.prdata = pwrite ? 32'h0000_0000 : rd;
      n.pslverr = ~hit;
    end else begin
      n.prdata = 32'h0000_0000;
      n.pslverr = 1'b0;
    end

    if (wr && hit) begin
      if (paddr == `KEY_ENTRY_OFF) begin
        n.unlocked = (pwdata[15:0] == q.key_cfg); // RULE20
      end else if (paddr == `OUT_REG_OFF) begin
        n.out_reg = pwdata[NPTS-1:0];
      end else if (paddr[11:6] == `AO_REGION) begin
        n.ao_val[paddr[2 +: IW]] = pwdata[15:0];
      end else if (q.unlocked) begin
        // Every other write is configuration and needs the key entered first.
        if (paddr == `CTRL_OFF) begin
          n.demo_en = pwdata[`CTRL_DEMO]; // RULE20
          n.sh3 = pwdata[`CTRL_SH3];
          n.sh4 = pwdata[`CTRL_SH4];
          n.scheme = (pwdata[`CTRL_SCHEME +: 4] > 4'(io_point_pkg::SCH_DN_RUNTIME)) ? io_point_pkg::SCH_OFF :
                     io_point_pkg::scheme_e'(pwdata[`CTRL_SCHEME +: 4]);
        end else if (paddr == `KEY_CFG_OFF) begin
          n.key_cfg = pwdata[15:0];
        end else if (paddr == `DEMO_TIME_OFF) begin
          n.demo_time = pwdata[15:0];
        end else if (paddr == `FLOAT_FAIL_OFF) begin
          n.ff_time = pwdata[15:0];
        end else if (paddr == `FLASH_HALF_OFF) begin
          n.flash_half = pwdata[15:0]; // RULE22
        end else if (paddr == `POINT_CFG_OFF) begin
          n.invert = pwdata[`PC_INVERT +: NPTS];
          n.slow = pwdata[`PC_SLOW +: NPTS];
          n.flash = pwdata[`PC_FLASH +: NPTS];
          n.mirror = pwdata[`PC_MIRROR +: NPTS];
          n.tb_en = pwdata[`PC_TB_EN +: NPTS];
          n.tb_src = pwdata[`PC_TB_SRC +: NPTS];
        end else if (paddr == `ANALOG_CFG_OFF) begin
          n.ai_mode = pwdata[`AC_AI_MODE +: NPTS];
          n.ao_mode = pwdata[`AC_AO_MODE +: NPTS];
          n.avg_code = (pwdata[`AC_AVG +: 3] > `AVG_MAX) ? `AVG_MAX : pwdata[`AC_AVG +: 3];
          n.ai_cnt = 6'h00;
        end else if (paddr[11:8] == `PT_REGION) begin
          if (fld == `PT_FILTER) n.filt[pi] = pwdata[15:0];
          else if (fld == `PT_ON) n.on_t[pi] = pwdata[15:0];
          else if (fld == `PT_HOLD) n.hold_t[pi] = pwdata[15:0];
          else n.rcy[pi] = pwdata[15:0];
        end else if (paddr[11:8] == `TB_REGION) begin
          if (fld == `TB_ON) n.tb_on[pi] = pwdata[15:0];
          else if (fld == `TB_OFF) n.tb_off[pi] = pwdata[15:0];
          else n.tb_idx[pi] = pwdata[IW-1:0];
        end
      end
    end

    // Mirroring is applied after the bus so the live input always wins its bit.
    for (k = 0; k < NPTS; k++) begin
      if (q.mirror[k]) begin
        n.out_reg[k] = q.cond[k]; // RULE16
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0; // RULE23
      q.key_cfg <= `KEY_RST;
      q.flash_half <= `FLASH_HALF_RST;
      q.demo_time <= `DEMO_TIME_RST;
      q.demo_pat <= NPTS'(`DEMO_PAT_RST);
    end else begin
      q <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output point timers, one per point.

  point_drive_if pif[NPTS] ();

  genvar g;
  generate
    for (g = 0; g < NPTS; g++) begin : g_pt
      assign pif[g].cmd = cmd[g];
      assign pif[g].force_off = force_off[g];
      assign pif[g].flash_en = q.flash[g];
      assign pif[g].t10 = q.t10;
      assign pif[g].t1s = q.t1s;
      assign pif[g].on_t = q.on_t[g];
      assign pif[g].hold_t = q.hold_t[g];
      assign pif[g].rcy = q.rcy[g];
      assign pif[g].flash_half = q.flash_half;
      assign phys_w[g] = pif[g].phys;
      point_drive u_drive (
        .pclk(pclk),
        .presetn(presetn),
        .bus(pif[g])
      );
    end
  endgenerate

  assign output_relay = phys_w;
  assign driven_level = q.drv;
  assign point_state = q.cond;
  assign pready = q.pready;
  assign prdata = q.prdata;
  assign pslverr = q.pslverr;

endmodule // io_point_conditioning_and_setpoint

`default_nettype wire

/* File: dv/io_point_chk.sv */
`timescale 1ns/1ps
`default_nettype none

module io_point_chk #(
  parameter int NPTS = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic [NPTS-1:0][15:0] driven_level
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic over;
  always_comb begin
    over = 1'b0;
    for (int i = 0; i < NPTS; i++) over |= driven_level[i] > 16'h4E20;
  end
  sequence slow_answer;
    !pready ##1 pready;
  endsequence
  ////////////////////
  a_ready_access: assert property (pready |-> psel && penable && $past(penable))
    else $error("pready outside access");
  a_ready_once: assert property (pready |=> !pready)
    else $error("pready held");
  a_setup_wait: assert property (psel && !penable |=> slow_answer)
    else $error("answer timing");
  a_ready_sel: assert property (pready |-> $past(psel, 2))
    else $error("pready without setup");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr alone");
  a_rdata_idle: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
    else $error("prdata not zero");
  a_level_clamp: assert property (!over)
    else $error("analog code over range");
  a_drive_cause: assert property ($changed(driven_level) |->
    $past(pready && pwrite) || $past(pready && pwrite, 2))
    else $error("analog change unprompted");
  cover property (pslverr);
  cover property (pready && !pwrite);
  cover property ($changed(driven_level));
endmodule // io_point_chk

bind io_point_conditioning_and_setpoint io_point_chk #(.NPTS(NPTS)) io_point_chk_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .driven_level(driven_level));

`default_nettype wire

/* File: dv/field_model.sv */
`timescale 1ns/1ps
`default_nettype none

module field_model (
  input wire logic pclk,
  input wire logic [3:0] want_pt,
  input wire logic [15:0] want_lvl,
  output logic [3:0] input_point = 4'h0,
  output logic [3:0][15:0] sensed_level = '0,
  output logic sensed_valid = 1'b0
);
  logic [1:0] div_q = 2'h0;
  // Contacts move just after an edge, so the block never sees a half-changed set.
  always @(posedge pclk) begin
    div_q <= div_q + 2'h1;
    input_point <= want_pt;
    sensed_level <= {4{want_lvl}};
    sensed_valid <= div_q == 2'h3;
  end
endmodule // field_model

`default_nettype wire

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sv, pready, pslverr, s_valid;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rdv, prdata;
  logic [3:0] ip, relay, st, wpt = 4'h0;
  logic [15:0] wlvl = 16'h0;
  logic [3:0][15:0] sl, dl;
  logic [15:0] lv [4] = '{16'h32, 16'h96, 16'hFA, 16'h96};
  logic [1:0] ex [4] = '{2'h1, 2'h1, 2'h2, 2'h2};
  int failures = 0, checks = 0, cyc = 0;
  always #5 pclk = ~pclk;
  // MS_CYCLES of 10 keeps a 10 ms step at 100 cycles.
  io_point_conditioning_and_setpoint #(.NPTS(4), .MS_CYCLES(10)) io_point_conditioning_and_setpoint_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .input_point(ip),
    .sensed_level(sl), .sensed_valid(s_valid), .output_relay(relay), .driven_level(dl), .point_state(st));
  field_model field_model_i (.pclk(pclk), .want_pt(wpt), .want_lvl(wlvl), .input_point(ip),
    .sensed_level(sl), .sensed_valid(s_valid));
  ////////////////////
  task automatic wrap_up();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdv = prdata;
    sv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures++;
      wrap_up();
    end
  end
  ////////////////////
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b1, 12'h01C, 32'h7);
    xfer(1'b0, 12'h01C, 32'h0);
    chk("flash", 32'h32, rdv);
    xfer(1'b1, 12'h004, 32'h0);
    xfer(1'b0, 12'h000, 32'h0);
    chk("unlock", 32'h100, rdv);
    xfer(1'b0, 12'hFF0, 32'h0);
    chk("slverr", 32'h1, {31'h0, sv});
    xfer(1'b1, 12'h020, 32'h30001);
    xfer(1'b1, 12'h120, 32'h5);
    repeat (10) @(posedge pclk);
    wpt <= 4'h4;
    repeat (20) @(posedge pclk);
    xfer(1'b0, 12'h010, 32'h0);
    chk("cond", 32'h1, {28'h0, rdv[3:0]});
    repeat (80) @(posedge pclk);
    xfer(1'b0, 12'h010, 32'h0);
    chk("filter", 32'h5, {28'h0, rdv[3:0]});
    chk("state", 32'h5, {28'h0, st});
    xfer(1'b1, 12'h108, 32'h3);
    xfer(1'b1, 12'h114, 32'h2);
    xfer(1'b1, 12'h00C, 32'h3);
    repeat (100) @(posedge pclk);
    chk("oneshot", 32'h2, {30'h0, relay[1:0]});
    repeat (300) @(posedge pclk);
    chk("ondelay", 32'h1, {30'h0, relay[1:0]});
    xfer(1'b1, 12'h340, 32'h5000);
    xfer(1'b1, 12'h024, 32'h30);
    xfer(1'b1, 12'h344, 32'h3E8);
    repeat (4) @(posedge pclk);
    chk("ao0", 32'h4E20, {16'h0, dl[0]});
    chk("ao1", 32'h1388, {16'h0, dl[1]});
    xfer(1'b1, 12'h200, 32'h64);
    xfer(1'b1, 12'h204, 32'hC8);
    xfer(1'b1, 12'h210, 32'hC8);
    xfer(1'b1, 12'h214, 32'h64);
    foreach (lv[k]) begin
      wlvl <= lv[k];
      repeat (30) @(posedge pclk);
      xfer(1'b0, 12'h010, 32'h0);
      chk("thresh", {30'h0, ex[k]}, {30'h0, rdv[17:16]});
    end
    xfer(1'b1, 12'h020, 32'h34001);
    xfer(1'b0, 12'h00C, 32'h0);
    chk("mirror", 32'h7, rdv);
    xfer(1'b1, 12'h000, 32'h4);
    wpt <= 4'hC;
    repeat (6) @(posedge pclk);
    chk("shutdown", 32'h4, {28'h0, relay});
    wrap_up();
  end
endmodule // tb_top

`default_nettype wire
